// [verilog/acr_pkg.sv]
package acr_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ACR_OFF_PRIMARY = 8'h00;
	localparam logic [7:0] ACR_OFF_SECONDARY = 8'h04;
	localparam logic [7:0] ACR_OFF_RESULT_HIGH = 8'h08;
	localparam logic [7:0] ACR_OFF_RESULT_LOW = 8'h0c;
	localparam logic [7:0] ACR_OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ACR_OFF_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] ACR_OFF_IRQ_CLEAR = 8'h18;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ACR_BIT_ENABLE = 0;
	localparam int ACR_BIT_GO = 1;
	localparam int ACR_POS_CHANNEL = 2;
	localparam int ACR_POS_CLKSEL = 6;
	localparam int ACR_BIT_POSREF = 4;
	localparam int ACR_BIT_NEGREF = 5;
	localparam int ACR_BIT_FORMAT = 7;
	localparam logic [7:0] ACR_SECONDARY_MASK = 8'hb0;
	localparam logic [7:0] ACR_PRIMARY_RESET = 8'h00;
	localparam logic [7:0] ACR_SECONDARY_RESET = 8'h00;

	// ----------------------------------------
	// clock select codes and divide ratios
	// ----------------------------------------
	localparam logic [1:0] ACR_CLK_DIV2 = 2'h0;
	localparam logic [1:0] ACR_CLK_DIV8 = 2'h1;
	localparam logic [1:0] ACR_CLK_DIV32 = 2'h2;
	localparam logic [1:0] ACR_CLK_INTOSC = 2'h3;
	localparam logic [5:0] ACR_HALF_DIV2 = 6'h01;
	localparam logic [5:0] ACR_HALF_DIV8 = 6'h04;
	localparam logic [5:0] ACR_HALF_DIV32 = 6'h10;
	localparam int ACR_FOSC_KHZ = 100000;
	localparam int ACR_INTOSC_MAX_KHZ = 500;
	// half period of the internal oscillator, shortest time rounds down
	localparam int ACR_INTOSC_HALF_CYC = ACR_FOSC_KHZ / (2 * ACR_INTOSC_MAX_KHZ);
	localparam logic [7:0] ACR_HALF_INTOSC = 8'(ACR_INTOSC_HALF_CYC);

	// ----------------------------------------
	// channel codes
	// ----------------------------------------
	localparam logic [3:0] ACR_CH_LAST_PIN = 4'hd;
	localparam logic [3:0] ACR_CH_CMP_REF = 4'he;
	localparam logic [3:0] ACR_CH_FIXED_REF = 4'hf;
	localparam logic [7:0] ACR_ABORT_TAD = 8'h02;

	typedef enum logic [1:0] {
		ACR_SRC_PIN,
		ACR_SRC_CMP_REF,
		ACR_SRC_FIXED_REF
	} acr_src_t;

	typedef struct packed {
		logic enable;
		logic conv_clk;
		logic conv_start;
		acr_src_t source;
		logic [3:0] pin_channel;
		logic pos_ref_ext;
		logic neg_ref_ext;
	} acr_core_ctrl_t;

	typedef struct packed {
		logic done;
		logic [9:0] value;
	} acr_core_result_t;

	function automatic logic [7:0] acr_half_period(input logic [1:0] sel);
		case (sel)
			ACR_CLK_DIV2: acr_half_period = {2'h0, ACR_HALF_DIV2};
			ACR_CLK_DIV8: acr_half_period = {2'h0, ACR_HALF_DIV8};
			ACR_CLK_DIV32: acr_half_period = {2'h0, ACR_HALF_DIV32};
			default: acr_half_period = ACR_HALF_INTOSC;
		endcase
	endfunction
endpackage

// [verilog/acr_clkgen.sv]
`timescale 1ns/1ps
module acr_clkgen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [1:0] sel,
	output logic conv_clk,
	output logic tad_tick
);
	import acr_pkg::*;
	logic [7:0] cnt_reg;
	logic [7:0] half;

	assign half = acr_half_period(sel);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
			conv_clk <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 8'h00;
			conv_clk <= 1'b0;
		end else if (cnt_reg >= half - 8'h01) begin
			cnt_reg <= 8'h00;
			conv_clk <= ~conv_clk;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// one pulse per full converter clock period
	assign tad_tick = run && conv_clk && (cnt_reg >= half - 8'h01);

	chk_clk_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		run && $past(run) && $past(cnt_reg) >= $past(half) - 8'h01 && half == $past(half)
		|-> conv_clk != $past(conv_clk))
		else $error("converter clock failed to toggle");
endmodule

// [verilog/acr_chsel.sv]
`timescale 1ns/1ps
module acr_chsel (
	input wire logic [3:0] code,
	output acr_pkg::acr_src_t source,
	output logic [3:0] pin_channel
);
	import acr_pkg::*;

	always_comb begin
		pin_channel = 4'h0;
		if (code <= ACR_CH_LAST_PIN) begin
			source = ACR_SRC_PIN;
			pin_channel = code;
		end else if (code == ACR_CH_CMP_REF) begin
			source = ACR_SRC_CMP_REF;
		end else begin
			source = ACR_SRC_FIXED_REF;
		end
	end
endmodule

// [verilog/acr_top.sv]
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module acr_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output acr_pkg::acr_core_ctrl_t core_ctrl,
	input wire acr_pkg::acr_core_result_t core_result,
	output logic acq_active,
	output logic irq
);
	import acr_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] primary_reg;
	logic [7:0] secondary_reg;
	logic [9:0] result_reg;
	logic irq_status_reg;
	logic irq_enable_reg;
	logic [7:0] abort_cnt_reg;
	logic acq_pending_reg;
	logic [31:0] rdata_next;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic go_write_one;
	logic go_write_zero;
	logic conv_done;
	logic conv_clk;
	logic tad_tick;
	acr_src_t source;
	logic [3:0] pin_channel;
	logic [15:0] result_packed;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign addr_ok = paddr == ACR_OFF_PRIMARY || paddr == ACR_OFF_SECONDARY
		|| paddr == ACR_OFF_RESULT_HIGH || paddr == ACR_OFF_RESULT_LOW
		|| paddr == ACR_OFF_IRQ_STATUS || paddr == ACR_OFF_IRQ_ENABLE
		|| paddr == ACR_OFF_IRQ_CLEAR;
	assign go_write_one = wr_en && paddr == ACR_OFF_PRIMARY && pwdata[ACR_BIT_GO];
	assign go_write_zero = wr_en && paddr == ACR_OFF_PRIMARY && !pwdata[ACR_BIT_GO];
	// a done from the core only counts while a conversion is live
	assign conv_done = core_result.done && primary_reg[ACR_BIT_GO]
		&& primary_reg[ACR_BIT_ENABLE];

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	acr_clkgen u_clkgen (
		.pclk(pclk),
		.presetn(presetn),
		.run(primary_reg[ACR_BIT_ENABLE]),
		.sel(primary_reg[ACR_POS_CLKSEL +: 2]),
		.conv_clk(conv_clk),
		.tad_tick(tad_tick)
	);

	acr_chsel u_chsel (
		.code(primary_reg[ACR_POS_CHANNEL +: 4]),
		.source(source),
		.pin_channel(pin_channel)
	);

	// ----------------------------------------
	// apb: zero wait states, error on unmapped
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
		end
	end

	// result justification per format bit
	always_comb begin
		if (secondary_reg[ACR_BIT_FORMAT]) begin
			result_packed = {6'h00, result_reg};
		end else begin
			result_packed = {result_reg, 6'h00};
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		case (paddr)
			ACR_OFF_PRIMARY: rdata_next = {24'h00_0000, primary_reg};
			ACR_OFF_SECONDARY: rdata_next = {24'h00_0000, secondary_reg & ACR_SECONDARY_MASK};
			ACR_OFF_RESULT_HIGH: rdata_next = {24'h00_0000, result_packed[15:8]};
			ACR_OFF_RESULT_LOW: rdata_next = {24'h00_0000, result_packed[7:0]};
			ACR_OFF_IRQ_STATUS: rdata_next = {31'h0000_0000, irq_status_reg};
			ACR_OFF_IRQ_ENABLE: rdata_next = {31'h0000_0000, irq_enable_reg};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// read data latched at setup, stable through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rdata_next;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// zero at reset, rw
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_reg <= ACR_PRIMARY_RESET;
		end else begin
			if (wr_en && paddr == ACR_OFF_PRIMARY) begin
				primary_reg <= pwdata[7:0];
				// go cannot start while converter is off or still recovering
				if (!pwdata[ACR_BIT_ENABLE] || abort_cnt_reg != 8'h00) begin
					primary_reg[ACR_BIT_GO] <= 1'b0;
				end
			end else if (conv_done || !primary_reg[ACR_BIT_ENABLE]) begin
				primary_reg[ACR_BIT_GO] <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			secondary_reg <= ACR_SECONDARY_RESET;
		end else if (wr_en && paddr == ACR_OFF_SECONDARY) begin
			secondary_reg <= pwdata[7:0] & ACR_SECONDARY_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= 10'h000;
		end else if (conv_done) begin
			result_reg <= core_result.value;
		end
	end

	// ----------------------------------------
	// abort recovery and auto acquisition
	// ----------------------------------------
	// two-period delay then acquire
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_cnt_reg <= 8'h00;
			acq_pending_reg <= 1'b0;
		end else if (!primary_reg[ACR_BIT_ENABLE]) begin
			abort_cnt_reg <= 8'h00;
			acq_pending_reg <= 1'b0;
		end else if (go_write_zero && primary_reg[ACR_BIT_GO] && !conv_done) begin
			abort_cnt_reg <= ACR_ABORT_TAD;
			acq_pending_reg <= 1'b0;
		end else if (abort_cnt_reg != 8'h00) begin
			if (tad_tick) begin
				abort_cnt_reg <= abort_cnt_reg - 8'h01;
				acq_pending_reg <= abort_cnt_reg == 8'h01;
			end
		end else if (go_write_one) begin
			acq_pending_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// interrupt
	// ----------------------------------------
	// sticky, set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_reg <= 1'b0;
		end else if (conv_done) begin
			irq_status_reg <= 1'b1;
		end else if (wr_en && paddr == ACR_OFF_IRQ_CLEAR && pwdata[0]) begin
			irq_status_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_reg <= 1'b0;
		end else if (wr_en && paddr == ACR_OFF_IRQ_ENABLE) begin
			irq_enable_reg <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (irq_status_reg || conv_done) && irq_enable_reg;
		end
	end

	// ----------------------------------------
	// core side outputs, all registered
	// ----------------------------------------
	// core interface
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_ctrl <= '0;
			acq_active <= 1'b0;
		end else begin
			core_ctrl.enable <= primary_reg[ACR_BIT_ENABLE];
			core_ctrl.conv_clk <= conv_clk;
			core_ctrl.conv_start <= primary_reg[ACR_BIT_GO] && !conv_done;
			core_ctrl.source <= source;
			core_ctrl.pin_channel <= pin_channel;
			core_ctrl.pos_ref_ext <= secondary_reg[ACR_BIT_POSREF];
			core_ctrl.neg_ref_ext <= secondary_reg[ACR_BIT_NEGREF];
			acq_active <= acq_pending_reg;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_done_seen;
		conv_done ##1 1'b1;
	endsequence

	chk_done_clears_go: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done && !wr_en |=> !primary_reg[ACR_BIT_GO])
		else $error("go still set after completion");
	chk_done_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		s_done_seen |-> irq_status_reg)
		else $error("flag not set on completion");
	chk_result_loaded: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done |=> result_reg == $past(core_result.value))
		else $error("result not loaded");
	chk_result_holds: assert property (@(posedge pclk) disable iff (!presetn)
		!conv_done |=> $stable(result_reg))
		else $error("result changed without completion");
	chk_go_starts: assert property (@(posedge pclk) disable iff (!presetn)
		go_write_one && pwdata[ACR_BIT_ENABLE] && abort_cnt_reg == 8'h00
		|=> primary_reg[ACR_BIT_GO] ##1 core_ctrl.conv_start || !primary_reg[ACR_BIT_GO])
		else $error("go write did not start");
	chk_secondary_mask: assert property (@(posedge pclk) disable iff (!presetn)
		(secondary_reg & ~ACR_SECONDARY_MASK) == 8'h00)
		else $error("unused secondary bit set");
	chk_enable_follows: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> core_ctrl.enable == $past(primary_reg[ACR_BIT_ENABLE]))
		else $error("enable not passed to core");
	chk_format_right: assert property (@(posedge pclk) disable iff (!presetn)
		secondary_reg[ACR_BIT_FORMAT] |-> result_packed[15:10] == 6'h00)
		else $error("right justify wrong");
	chk_fixed_ref: assert property (@(posedge pclk) disable iff (!presetn)
		primary_reg[ACR_POS_CHANNEL +: 4] == ACR_CH_FIXED_REF
		|=> core_ctrl.source == ACR_SRC_FIXED_REF)
		else $error("fixed reference not routed");
	chk_pin_route: assert property (@(posedge pclk) disable iff (!presetn)
		primary_reg[ACR_POS_CHANNEL +: 4] <= ACR_CH_LAST_PIN
		|=> core_ctrl.source == ACR_SRC_PIN
		&& core_ctrl.pin_channel == $past(primary_reg[ACR_POS_CHANNEL +: 4]))
		else $error("pin channel not routed");

	// ----------------------------------------
	// recovery, interrupt and bus checks
	// ----------------------------------------
	// an abort is a go-clearing write landing while a conversion is live
	sequence s_abort_write;
		go_write_zero && primary_reg[ACR_BIT_GO] && primary_reg[ACR_BIT_ENABLE] && !conv_done;
	endsequence

	sequence s_last_tick;
		abort_cnt_reg == 8'h01 && tad_tick && primary_reg[ACR_BIT_ENABLE];
	endsequence

	chk_abort_arms: assert property (@(posedge pclk) disable iff (!presetn)
		s_abort_write |=> abort_cnt_reg == ACR_ABORT_TAD)
		else $error("abort did not start recovery");
	chk_recover_no_go: assert property (@(posedge pclk) disable iff (!presetn)
		abort_cnt_reg != 8'h00 |-> !primary_reg[ACR_BIT_GO])
		else $error("go set during recovery");
	chk_acq_not_early: assert property (@(posedge pclk) disable iff (!presetn)
		abort_cnt_reg != 8'h00 |-> !acq_pending_reg)
		else $error("acquisition before recovery ended");
	chk_acq_after_abort: assert property (@(posedge pclk) disable iff (!presetn)
		s_last_tick |=> acq_pending_reg && abort_cnt_reg == 8'h00)
		else $error("acquisition did not follow recovery");
	chk_go_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		go_write_one && (!pwdata[ACR_BIT_ENABLE] || abort_cnt_reg != 8'h00)
		|=> !primary_reg[ACR_BIT_GO])
		else $error("refused go write took effect");
	chk_go_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
		primary_reg[ACR_BIT_GO] |-> primary_reg[ACR_BIT_ENABLE])
		else $error("busy while converter off");
	chk_off_clears_acq: assert property (@(posedge pclk) disable iff (!presetn)
		!primary_reg[ACR_BIT_ENABLE] |=> !acq_pending_reg && abort_cnt_reg == 8'h00)
		else $error("recovery state kept while off");
	chk_clk_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!primary_reg[ACR_BIT_ENABLE] |=> !conv_clk)
		else $error("converter clock runs while off");
	chk_start_needs_go: assert property (@(posedge pclk) disable iff (!presetn)
		core_ctrl.conv_start |-> $past(primary_reg[ACR_BIT_GO]))
		else $error("start without go");
	chk_ref_routing: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> core_ctrl.pos_ref_ext == $past(secondary_reg[ACR_BIT_POSREF])
		&& core_ctrl.neg_ref_ext == $past(secondary_reg[ACR_BIT_NEGREF]))
		else $error("reference selection not routed");
	chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		irq_status_reg && !(wr_en && paddr == ACR_OFF_IRQ_CLEAR && pwdata[0]) |=> irq_status_reg)
		else $error("flag dropped without clear");
	chk_irq_raised: assert property (@(posedge pclk) disable iff (!presetn)
		irq_status_reg && irq_enable_reg |=> irq)
		else $error("enabled flag gave no interrupt");
	chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
		!irq_enable_reg |=> !irq)
		else $error("interrupt while disabled");
	// a ready held over would let the master end a transfer without setup
	chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !addr_ok |=> pready && pslverr)
		else $error("unmapped access without error");
endmodule

// [testbench/acr_core_model.sv]
`timescale 1ns/1ps
module acr_core_model
	import acr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire acr_pkg::acr_core_ctrl_t core_ctrl,
	input wire logic [9:0] sample,
	output acr_pkg::acr_core_result_t core_result
);
	localparam int CONV_EDGES = 4;
	logic clk_prev;
	int edges;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev <= 1'b0;
			edges <= 0;
			core_result <= '0;
		end else begin
			clk_prev <= core_ctrl.conv_clk;
			core_result.done <= 1'b0;
			// value is junk outside the done pulse, so stale data is never trusted
			core_result.value <= ~core_result.value;
			if (!(core_ctrl.enable && core_ctrl.conv_start)) begin
				edges <= 0;
			end else if (core_ctrl.conv_clk && !clk_prev) begin
				if (edges == CONV_EDGES - 1) begin
					edges <= 0;
					core_result.done <= 1'b1;
					core_result.value <= sample;
				end else begin
					edges <= edges + 1;
				end
			end
		end
	end
endmodule

// [testbench/tb_adc_control_registers.sv]
`timescale 1ns/1ps
module tb_adc_control_registers;
	import acr_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	acr_core_ctrl_t core_ctrl;
	acr_core_result_t core_result;
	logic acq_active;
	logic irq;
	logic [9:0] sample = 10'h000;
	logic [31:0] rdata;
	logic err;
	int errors = 0;
	int tests_run = 0;
	int seed = 32'h03e85025;
	int cyc = 0;
	int last_rise = 0;
	int period = 0;
	logic clk_d = 1'b0;
	int prim_m;
	int sec_m;
	int res_q[$];

	always #5 pclk = ~pclk;

	acr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_ctrl(core_ctrl), .core_result(core_result),
		.acq_active(acq_active), .irq(irq));
	acr_core_model u_core (.pclk(pclk), .presetn(presetn), .core_ctrl(core_ctrl),
		.sample(sample), .core_result(core_result));

	// converter clock period in pclk cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		clk_d <= core_ctrl.conv_clk;
		if (core_ctrl.conv_clk && !clk_d) begin
			period <= cyc - last_rise;
			last_rise <= cyc;
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		check(n < 20, 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		give_verdict();
	end

	initial begin
		int n;
		logic [31:0] v;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, ACR_OFF_PRIMARY, 0);
		check(rdata, 0);
		apb(0, ACR_OFF_SECONDARY, 0);
		check(rdata, 0);
		apb(0, 8'h40, 0);
		check(err, 1'b1);
		check(rdata, 0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			apb(1, ACR_OFF_SECONDARY, v);
			sec_m = v[7:0] & 8'hb0;
			apb(0, ACR_OFF_SECONDARY, 0);
			check(rdata, sec_m);
			check({core_ctrl.neg_ref_ext, core_ctrl.pos_ref_ext}, sec_m[5:4]);
		end
		$display("test secondary done");
		for (int c = 0; c < 16; c++) begin
			prim_m = c << 2;
			apb(1, ACR_OFF_PRIMARY, prim_m);
			apb(0, ACR_OFF_PRIMARY, 0);
			check(rdata, prim_m);
			check(core_ctrl.source, c < 14 ? ACR_SRC_PIN : c == 14 ? ACR_SRC_CMP_REF
				: ACR_SRC_FIXED_REF);
			if (c < 14)
				check(core_ctrl.pin_channel, c);
		end
		apb(1, 8'h1c, 32'hff);
		check(err, 1'b1);
		apb(0, ACR_OFF_PRIMARY, 0);
		check(rdata, prim_m);
		$display("test channels done");
		for (int s = 0; s < 4; s++) begin
			apb(1, ACR_OFF_IRQ_ENABLE, s & 1);
			apb(1, ACR_OFF_SECONDARY, (s >> 1) << 7);
			sample <= 10'($random(seed));
			prim_m = (s << 6) | (5 << 2) | 1;
			apb(1, ACR_OFF_PRIMARY, prim_m);
			apb(1, ACR_OFF_PRIMARY, prim_m | 2);
			apb(0, ACR_OFF_PRIMARY, 0);
			check(rdata[1], 1'b1);
			check(core_ctrl.conv_start, 1'b1);
			n = 0;
			do begin
				apb(0, ACR_OFF_PRIMARY, 0);
				n++;
			end while (rdata[1] === 1'b1 && n < 400);
			check(rdata, prim_m);
			check(core_ctrl.conv_start, 1'b0);
			check(s == 3 ? period >= 200 : period == (2 << (2 * s)), 1'b1);
			res_q.push_back(sample);
			apb(0, ACR_OFF_RESULT_HIGH, 0);
			check(rdata, s > 1 ? sample[9:8] : sample[9:2]);
			apb(0, ACR_OFF_RESULT_LOW, 0);
			check(rdata, s > 1 ? sample[7:0] : {sample[1:0], 6'h00});
			apb(0, ACR_OFF_IRQ_STATUS, 0);
			check(rdata, 1);
			check(irq, s & 1);
			apb(1, ACR_OFF_IRQ_CLEAR, 1);
			apb(0, ACR_OFF_IRQ_STATUS, 0);
			check(irq, 1'b0);
			check(rdata, 0);
		end
		$display("test conversions done");
		sample <= ~sample;
		apb(1, ACR_OFF_PRIMARY, (2 << 6) | 1);
		apb(1, ACR_OFF_PRIMARY, (2 << 6) | 3);
		apb(1, ACR_OFF_PRIMARY, (2 << 6) | 1);
		n = 0;
		while (acq_active !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		check(acq_active, 1'b1);
		check(n > 32 && n < 70, 1'b1);
		apb(0, ACR_OFF_RESULT_LOW, 0);
		check(rdata, res_q[$][7:0]);
		apb(0, ACR_OFF_IRQ_STATUS, 0);
		check(rdata, 0);
		$display("test abort done");
		apb(1, ACR_OFF_PRIMARY, (3 << 2) | 2);
		apb(0, ACR_OFF_PRIMARY, 0);
		check(rdata[1:0], 2'h0);
		check(core_ctrl.enable, 1'b0);
		check(acq_active, 1'b0);
		$display("test disable done");
		give_verdict();
	end
endmodule
